// ===== src/psg_map.vh
// Register offsets, field positions, reset values and timing counts of the pulse/sync block
`ifndef PSG_MAP_VH
`define PSG_MAP_VH

// ********************************************************************
// Register offsets (byte addresses)
// ********************************************************************
`define PSG_OFS_CTRL 8'h00
`define PSG_OFS_PER_LO 8'h04
`define PSG_OFS_PER_HI 8'h08
`define PSG_OFS_WID_LO 8'h0c
`define PSG_OFS_WID_HI 8'h10
`define PSG_OFS_EDGE 8'h14
`define PSG_OFS_DUTY 8'h18
`define PSG_OFS_EWID_LO 8'h1c
`define PSG_OFS_EWID_HI 8'h20
`define PSG_OFS_STAT 8'h24

// ********************************************************************
// Control register fields
// ********************************************************************
`define PSG_CTRL_INV 0
`define PSG_CTRL_SYNC_EN 1
`define PSG_CTRL_FUNC_LSB 2
`define PSG_CTRL_FUNC_MSB 4
`define PSG_CTRL_MOD_EN 5
`define PSG_CTRL_MOD_EXT 6
`define PSG_CTRL_SWEEP_EN 7
`define PSG_CTRL_MARKER_EN 8
`define PSG_CTRL_BURST_EN 9
`define PSG_CTRL_BURST_GATED 10
`define PSG_CTRL_BURST_INF 11
`define PSG_CTRL_RESET 12'h002

// Function codes
`define PSG_FN_SINE 3'h0
`define PSG_FN_SQUARE 3'h1
`define PSG_FN_RAMP 3'h2
`define PSG_FN_PULSE 3'h3
`define PSG_FN_NOISE 3'h4
`define PSG_FN_DC 3'h5
`define PSG_FN_ARB 3'h6

// Status register fields
`define PSG_STAT_PHASE 0
`define PSG_STAT_SYNC 1
`define PSG_STAT_BUSY 2
`define PSG_STAT_EDGE_LSB 8

// ********************************************************************
// Times in ns and their cycle counts
// ********************************************************************
`define PSG_CLK_NS 64'd4
`define PSG_PER_MIN_NS 64'd200
`define PSG_PER_MAX_NS 64'd1000000000000
`define PSG_PER_DEF_NS 64'd1000000
`define PSG_WID_DEF_NS 64'd100000
`define PSG_EDGE_MIN_NS 64'd20
`define PSG_EDGE_MAX_NS 64'd100
`define PSG_EDGE_DEF_NS 64'd20
`define PSG_WMIN_A_NS 64'd40
`define PSG_WMIN_B_NS 64'd200
`define PSG_WMIN_C_NS 64'd2000
`define PSG_PER_10S_NS 64'd10000000000
`define PSG_PER_100S_NS 64'd100000000000
`define PSG_DUTY_DEF 7'h0a
`define PSG_DUTY_FULL 8'h64

// Least times round up, longest times round down
`define PSG_CYC_UP(t) (((t) + `PSG_CLK_NS - 64'd1) / `PSG_CLK_NS)
`define PSG_CYC_DN(t) ((t) / `PSG_CLK_NS)

`endif

// ===== src/psg_pulse_sync.v
// Pulse waveform timing, parameter clamping and sync output selection
//
// Our own choices: the plain strobed port and the placing of the registers.
`include "psg_map.vh"
`default_nettype none

module psg_pulse_sync (
    input wire clk_sys_i,
    input wire rst_i,
    input wire ce_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    input wire carrier_half_i,
    input wire square_hi_i,
    input wire mod_half_i,
    input wire sweep_start_i,
    input wire sweep_mid_i,
    input wire marker_hit_i,
    input wire burst_start_i,
    input wire burst_done_i,
    input wire cycle_end_i,
    input wire gate_i,
    input wire nv_load_i,
    input wire nv_sync_i,
    output reg main_o,
    output reg pulse_hi_o,
    output reg invert_o,
    output reg sync_o,
    output reg [7:0] edge_o,
    output reg nv_sync_o
);
    // ****************************************************************
    // Constants in cycles
    // ****************************************************************
    localparam [63:0] PER_MIN_W = `PSG_CYC_UP(`PSG_PER_MIN_NS);
    localparam [63:0] PER_MAX_W = `PSG_CYC_DN(`PSG_PER_MAX_NS);
    localparam [63:0] PER_DEF_W = `PSG_CYC_DN(`PSG_PER_DEF_NS);
    localparam [63:0] WID_DEF_W = `PSG_CYC_DN(`PSG_WID_DEF_NS);
    localparam [63:0] EDGE_MIN_W = `PSG_CYC_UP(`PSG_EDGE_MIN_NS);
    localparam [63:0] EDGE_MAX_W = `PSG_CYC_DN(`PSG_EDGE_MAX_NS);
    localparam [63:0] EDGE_DEF_W = `PSG_CYC_DN(`PSG_EDGE_DEF_NS);
    localparam [63:0] WMIN_A_W = `PSG_CYC_UP(`PSG_WMIN_A_NS);
    localparam [63:0] WMIN_B_W = `PSG_CYC_UP(`PSG_WMIN_B_NS);
    localparam [63:0] WMIN_C_W = `PSG_CYC_UP(`PSG_WMIN_C_NS);
    localparam [63:0] PER_10S_W = `PSG_CYC_DN(`PSG_PER_10S_NS);
    localparam [63:0] PER_100S_W = `PSG_CYC_DN(`PSG_PER_100S_NS);
    localparam [39:0] PER_MIN = PER_MIN_W[39:0];
    localparam [39:0] PER_MAX = PER_MAX_W[39:0];
    localparam [7:0] EDGE_MIN = EDGE_MIN_W[7:0];
    localparam [7:0] EDGE_MAX = EDGE_MAX_W[7:0];
    localparam [39:0] WMIN_A = WMIN_A_W[39:0];
    localparam [39:0] WMIN_B = WMIN_B_W[39:0];
    localparam [39:0] WMIN_C = WMIN_C_W[39:0];
    localparam [39:0] PER_10S = PER_10S_W[39:0];
    localparam [39:0] PER_100S = PER_100S_W[39:0];
    localparam [7:0] DUTY_FULL = `PSG_DUTY_FULL;
    localparam [5:0] DIV_STEPS = 6'd47;
    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [11:0] ctrl_r;
    reg [39:0] per_req_r;
    reg [39:0] wid_req_r;
    reg [7:0] edge_req_r;
    reg [6:0] duty_r;
    reg [39:0] per_eff_r;
    reg [39:0] wid_eff_r;
    reg [7:0] edge_eff_r;
    reg [39:0] cnt_r;
    reg [46:0] dv_num_r;
    reg [6:0] dv_rem_r;
    reg [5:0] dv_cnt_r;
    reg dv_busy_r;
    reg gate_m_r;
    reg gate_s_r;
    reg sweep_flag_r;
    reg burst_flag_r;
    reg gate_hold_r;
    wire inv = ctrl_r[`PSG_CTRL_INV];
    wire sync_en = ctrl_r[`PSG_CTRL_SYNC_EN];
    wire [2:0] func = ctrl_r[`PSG_CTRL_FUNC_MSB:`PSG_CTRL_FUNC_LSB];
    wire mod_en = ctrl_r[`PSG_CTRL_MOD_EN];
    wire mod_ext = ctrl_r[`PSG_CTRL_MOD_EXT];
    wire sweep_en = ctrl_r[`PSG_CTRL_SWEEP_EN];
    wire marker_en = ctrl_r[`PSG_CTRL_MARKER_EN];
    wire burst_en = ctrl_r[`PSG_CTRL_BURST_EN];
    wire burst_gated = ctrl_r[`PSG_CTRL_BURST_GATED];
    wire burst_inf = ctrl_r[`PSG_CTRL_BURST_INF];
    // ****************************************************************
    // Parameter clamping
    // ****************************************************************
    reg [39:0] per_c;
    reg [7:0] edge_c;
    reg [39:0] wmin;
    reg [39:0] e16;
    reg [39:0] w_lo;
    reg [39:0] w_hi;
    reg [39:0] w_c;
    reg [42:0] w5;
    reg [39:0] e_max;
    reg [7:0] e_c;
    reg [10:0] e8;
    // Clamp period, edge and width against each other
    always @*
    begin
        per_c = per_req_r;
        if (per_req_r < PER_MIN)
            per_c = PER_MIN;
        else if (per_req_r > PER_MAX)
            per_c = PER_MAX;
        edge_c = edge_req_r;
        if (edge_req_r < EDGE_MIN)
            edge_c = EDGE_MIN;
        else if (edge_req_r > EDGE_MAX)
            edge_c = EDGE_MAX;
        if (per_c <= PER_10S)
            wmin = WMIN_A;
        else if (per_c <= PER_100S)
            wmin = WMIN_B;
        else
            wmin = WMIN_C;
        // 1.6 times edge, rounded up
        e8 = {edge_c, 3'b000} + 11'h004;
        e16 = {29'h0, e8 / 11'h005};
        w_lo = (wmin > e16) ? wmin : e16;
        w_hi = per_c - wmin - 40'h1;
        if (per_c - e16 < w_hi)
            w_hi = per_c - e16;
        w_c = wid_req_r;
        if (w_c < w_lo)
            w_c = w_lo;
        if (w_c > w_hi)
            w_c = w_hi;
        // Edge at most 5/8 of width
        w5 = {w_c, 2'b00} + {3'h0, w_c};
        e_max = w5[42:3];
        e_c = edge_c;
        if ({32'h0, edge_c} > e_max)
            e_c = e_max[7:0];
        if (e_c < EDGE_MIN)
            e_c = EDGE_MIN;
    end
    // ****************************************************************
    // Register port
    // ****************************************************************
    wire duty_wr = wr_i && (addr_i == `PSG_OFS_DUTY);
    wire [6:0] duty_in = (wdata_i[7:0] > DUTY_FULL) ? DUTY_FULL[6:0] : wdata_i[6:0];
    wire [7:0] rem_sh = {dv_rem_r, dv_num_r[46]};
    wire rem_ge = rem_sh >= DUTY_FULL;
    wire [7:0] rem_sub = rem_sh - DUTY_FULL;
    // Writes, duty-to-width division, non-volatile restore
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= `PSG_CTRL_RESET;
            per_req_r <= PER_DEF_W[39:0];
            wid_req_r <= WID_DEF_W[39:0];
            edge_req_r <= EDGE_DEF_W[7:0];
            duty_r <= `PSG_DUTY_DEF;
            dv_num_r <= 47'h0;
            dv_rem_r <= 7'h0;
            dv_cnt_r <= 6'h0;
            dv_busy_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (nv_load_i)
                ctrl_r[`PSG_CTRL_SYNC_EN] <= nv_sync_i;
            if (wr_i)
            begin
                case (addr_i)
                    `PSG_OFS_CTRL: ctrl_r <= wdata_i[11:0];
                    `PSG_OFS_PER_LO: per_req_r[31:0] <= wdata_i;
                    `PSG_OFS_PER_HI: per_req_r[39:32] <= wdata_i[7:0];
                    `PSG_OFS_WID_LO: wid_req_r[31:0] <= wdata_i;
                    `PSG_OFS_WID_HI: wid_req_r[39:32] <= wdata_i[7:0];
                    `PSG_OFS_EDGE: edge_req_r <= wdata_i[7:0];
                    `PSG_OFS_DUTY: duty_r <= duty_in;
                    default: ;
                endcase
            end
            if (duty_wr)
            begin
                // Width = period * duty / 100, restoring division
                dv_num_r <= per_c * duty_in;
                dv_rem_r <= 7'h0;
                dv_cnt_r <= DIV_STEPS;
                dv_busy_r <= 1'b1;
            end
            else if (dv_busy_r)
            begin
                dv_num_r <= {dv_num_r[45:0], rem_ge};
                dv_rem_r <= rem_ge ? rem_sub[6:0] : rem_sh[6:0];
                dv_cnt_r <= dv_cnt_r - 6'h1;
                // Last quotient bit; a zero width lands as well
                if (dv_cnt_r == 6'h1)
                begin
                    dv_busy_r <= 1'b0;
                    wid_req_r <= {dv_num_r[38:0], rem_ge};
                end
            end
        end
    end
    // Read data, valid only in the cycle after the read strobe
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
            rdata_o <= 32'h0;
        else if (ce_i)
        begin
            rdata_o <= 32'h0;
            if (rd_i)
            begin
                case (addr_i)
                    `PSG_OFS_CTRL: rdata_o <= {20'h0, ctrl_r};
                    `PSG_OFS_PER_LO: rdata_o <= per_req_r[31:0];
                    `PSG_OFS_PER_HI: rdata_o <= {24'h0, per_req_r[39:32]};
                    `PSG_OFS_WID_LO: rdata_o <= wid_req_r[31:0];
                    `PSG_OFS_WID_HI: rdata_o <= {24'h0, wid_req_r[39:32]};
                    `PSG_OFS_EDGE: rdata_o <= {24'h0, edge_req_r};
                    `PSG_OFS_DUTY: rdata_o <= {25'h0, duty_r};
                    `PSG_OFS_EWID_LO: rdata_o <= wid_eff_r[31:0];
                    `PSG_OFS_EWID_HI: rdata_o <= {24'h0, wid_eff_r[39:32]};
                    `PSG_OFS_STAT: rdata_o <= {16'h0, edge_eff_r, 5'h0, dv_busy_r,
                        sync_o, pulse_hi_o};
                    default: rdata_o <= 32'h0;
                endcase
            end
        end
    end
    // ****************************************************************
    // Pulse timing
    // ****************************************************************
    wire [39:0] per_last = per_eff_r - 40'h1;
    // High phase starts only at count zero, so a wider setting never makes a runt
    wire pulse_phase = (cnt_r < wid_eff_r) && (cnt_r == 40'h0 || pulse_hi_o);
    wire pulse_half = cnt_r < {1'b0, per_eff_r[39:1]};
    // Effective settings and period counter
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            per_eff_r <= PER_DEF_W[39:0];
            wid_eff_r <= WID_DEF_W[39:0];
            edge_eff_r <= EDGE_DEF_W[7:0];
            cnt_r <= 40'h0;
            main_o <= 1'b0;
            pulse_hi_o <= 1'b0;
            invert_o <= 1'b0;
            edge_o <= EDGE_DEF_W[7:0];
            nv_sync_o <= 1'b1;
        end
        else if (ce_i)
        begin
            per_eff_r <= per_c;
            wid_eff_r <= w_c;
            edge_eff_r <= e_c;
            edge_o <= edge_eff_r;
            if (cnt_r >= per_last)
                cnt_r <= 40'h0;
            else
                cnt_r <= cnt_r + 40'h1;
            // Width counted 50% to 50%; the analog stage adds the edges
            pulse_hi_o <= pulse_phase;
            // Inversion about the offset: only the swing flips
            main_o <= pulse_phase ^ inv;
            invert_o <= inv;
            nv_sync_o <= sync_en;
        end
    end
    // ****************************************************************
    // Sync generation
    // ****************************************************************
    // Gate pin synchroniser and sweep/burst state; set wins over clear
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            gate_m_r <= 1'b0;
            gate_s_r <= 1'b0;
            sweep_flag_r <= 1'b0;
            burst_flag_r <= 1'b0;
            gate_hold_r <= 1'b0;
        end
        else if (ce_i)
        begin
            gate_m_r <= gate_i;
            gate_s_r <= gate_m_r;
            if (sweep_start_i)
                sweep_flag_r <= 1'b1;
            else if (marker_en ? marker_hit_i : sweep_mid_i)
                sweep_flag_r <= 1'b0;
            if (burst_start_i)
                burst_flag_r <= 1'b1;
            else if (burst_done_i)
                burst_flag_r <= 1'b0;
            if (gate_s_r)
                gate_hold_r <= 1'b1;
            else if (cycle_end_i)
                gate_hold_r <= 1'b0;
        end
    end
    reg sync_nxt;
    // Sync source by mode; polarity never enters here
    always @*
    begin
        sync_nxt = 1'b0;
        if (sweep_en && marker_en)
            sync_nxt = sweep_flag_r;
        else if (!sync_en)
            sync_nxt = 1'b0;
        else if (func == `PSG_FN_NOISE || func == `PSG_FN_DC)
            sync_nxt = 1'b0;
        else if (sweep_en)
            sync_nxt = sweep_flag_r;
        else if (burst_en && burst_gated)
            sync_nxt = gate_s_r | gate_hold_r;
        else if (burst_en && !burst_inf)
            sync_nxt = burst_flag_r;
        else if (mod_en)
            sync_nxt = mod_ext ? carrier_half_i : mod_half_i;
        else
        begin
            case (func)
                `PSG_FN_SQUARE: sync_nxt = square_hi_i;
                `PSG_FN_PULSE: sync_nxt = pulse_half;
                `PSG_FN_ARB: sync_nxt = carrier_half_i;
                default: sync_nxt = carrier_half_i;
            endcase
        end
    end
    // Sync pin register
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
            sync_o <= 1'b0;
        else if (ce_i)
            sync_o <= sync_nxt;
    end

endmodule

`default_nettype wire

// ===== test/psg_pulse_sync_props.sv
// Port-level assertions for the pulse and sync block
`default_nettype none
module psg_pulse_sync_props (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic nv_load_i,
    input wire logic nv_sync_i,
    input wire logic [31:0] rdata_o,
    input wire logic main_o,
    input wire logic pulse_hi_o,
    input wire logic invert_o,
    input wire logic sync_o,
    input wire logic [7:0] edge_o,
    input wire logic nv_sync_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    a_main_polarity: assert property (main_o == (pulse_hi_o ^ invert_o))
        else $error("main output not pulse phase xor polarity");
    a_reset_state: assert property (disable iff (1'b0) rst_i && ce_i |=>
        edge_o == 8'h05 && nv_sync_o && !sync_o && !main_o)
        else $error("reset state wrong");
    a_nv_restore: assert property (nv_load_i && ce_i && !wr_i |->
        ##[1:3] nv_sync_o == nv_sync_i)
        else $error("stored sync enable not restored");
    a_nv_follow: assert property ($changed(nv_sync_o) |->
        $past(wr_i, 2) || $past(wr_i, 3) || $past(nv_load_i) || $past(nv_load_i, 2))
        else $error("sync enable changed without cause");
    a_edge_bounds: assert property (edge_o >= 8'h05 && edge_o <= 8'h19)
        else $error("edge time out of range");
    a_width_floor: assert property ($fell(pulse_hi_o) |-> $past(pulse_hi_o, 8))
        else $error("pulse high phase too short");
    a_sync_steady: assert property ($changed(invert_o) |-> $stable(sync_o))
        else $error("sync moved with polarity");
    a_rdata_idle: assert property ($past(ce_i) && !$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read answer");
    // Main scenarios
    c_sync_rise: cover property ($rose(sync_o));
    c_invert: cover property ($rose(invert_o));
    c_pulse_fall: cover property ($fell(pulse_hi_o));
endmodule
bind psg_pulse_sync psg_pulse_sync_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ce_i(ce_i), .wr_i(wr_i), .rd_i(rd_i), .nv_load_i(nv_load_i), .nv_sync_i(nv_sync_i),
    .rdata_o(rdata_o), .main_o(main_o), .pulse_hi_o(pulse_hi_o), .invert_o(invert_o),
    .sync_o(sync_o), .edge_o(edge_o), .nv_sync_o(nv_sync_o));
`default_nettype wire

// ===== test/psg_pulse_sync_test.sv
// Self-checking bench of the pulse and sync block
`include "psg_map.vh"
`default_nettype none
module psg_pulse_sync_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [8:0] ev = 9'h0; // Carrier, square, mod, start, mid, marker, bstart, bdone, cend
    logic gate_i = 1'b0;
    logic nv_load_i = 1'b0;
    logic nv_sync_i = 1'b0;
    logic ce_i = 1'b1;
    logic [31:0] rv;
    wire [31:0] rdata_o;
    wire main_o, pulse_hi_o, invert_o, sync_o, nv_sync_o;
    wire [7:0] edge_o;
    wire [15:0] s_hi, s_per, m_hi, m_per;
    int mismatches = 0;
    int compares = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    psg_pulse_sync dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .carrier_half_i(ev[0]), .square_hi_i(ev[1]), .mod_half_i(ev[2]),
        .sweep_start_i(ev[3]), .sweep_mid_i(ev[4]), .marker_hit_i(ev[5]),
        .burst_start_i(ev[6]), .burst_done_i(ev[7]), .cycle_end_i(ev[8]), .gate_i(gate_i),
        .nv_load_i(nv_load_i), .nv_sync_i(nv_sync_i), .main_o(main_o),
        .pulse_hi_o(pulse_hi_o), .invert_o(invert_o), .sync_o(sync_o), .edge_o(edge_o),
        .nv_sync_o(nv_sync_o));
    psg_rx u_srx (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .line_i(sync_o), .hi_len_o(s_hi),
        .per_len_o(s_per));
    psg_rx u_mrx (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .line_i(main_o), .hi_len_o(m_hi),
        .per_len_o(m_per));
    // ********************************************************************
    // Bus and check helpers
    // ********************************************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic lvl(input int b, input logic v);
        @(posedge clk_sys_i);
        ev[b] <= v;
    endtask
    task automatic ewid(input logic [7:0] a, input logic [31:0] d, input int n);
        wr(a, d);
        cyc(n);
        rd(`PSG_OFS_EWID_LO);
    endtask
    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic t_reset;
        rd(`PSG_OFS_CTRL);
        chk(rv, `PSG_CTRL_RESET);
        rd(`PSG_OFS_DUTY);
        chk(rv, `PSG_DUTY_DEF);
        rd(`PSG_OFS_EWID_LO);
        chk(rv, 32'd25000);
        rd(8'h3c);
        chk(rv, 32'h0);
        chk({edge_o, nv_sync_o}, {8'h05, 1'b1});
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        wr(`PSG_OFS_CTRL, 32'h001);
        ce_i <= 1'b1;
        rd(`PSG_OFS_CTRL);
        chk(rv, `PSG_CTRL_RESET);
        $display("reset test done");
    endtask
    task automatic t_polarity;
        lvl(0, 1'b1);
        wr(`PSG_OFS_CTRL, 32'h003);
        cyc(4);
        chk({invert_o, main_o ^ pulse_hi_o, sync_o}, 3'h7);
        wr(`PSG_OFS_CTRL, 32'h002);
        cyc(4);
        chk({invert_o, main_o ^ pulse_hi_o, sync_o}, 3'h1);
        wr(`PSG_OFS_CTRL, 32'h000);
        cyc(4);
        chk({sync_o, nv_sync_o}, 2'h0);
        @(posedge clk_sys_i);
        nv_sync_i <= 1'b1;
        nv_load_i <= 1'b1;
        @(posedge clk_sys_i);
        nv_load_i <= 1'b0;
        cyc(4);
        chk({sync_o, nv_sync_o}, 2'h3);
        $display("polarity and enable test done");
    endtask
    task automatic t_funcs;
        logic ex;
        for (int f = 0; f < 7; f++)
        begin
            wr(`PSG_OFS_CTRL, {27'h0, f[2:0], 2'h2});
            for (int v = 0; v < 2; v++)
            begin
                lvl(0, v[0]);
                lvl(1, !v[0]);
                cyc(3);
                ex = (f == 4 || f == 5) ? 1'b0 : (f == 1) ? !v[0] : v[0];
                if (f != 3)
                    chk(sync_o, ex);
            end
        end
        $display("function sync test done");
    endtask
    task automatic t_pulse;
        wr(`PSG_OFS_CTRL, 32'h00e);
        wr(`PSG_OFS_PER_LO, 32'd100);
        wr(`PSG_OFS_WID_LO, 32'd30);
        cyc(350);
        chk({s_hi, s_per, m_hi, m_per}, {16'd50, 16'd100, 16'd30, 16'd100});
        ewid(`PSG_OFS_WID_LO, 32'd99, 8);
        chk(rv, 32'd89);
        ewid(`PSG_OFS_WID_LO, 32'd2, 8);
        chk(rv, 32'd10);
        ewid(`PSG_OFS_PER_HI, 32'd1, 8);
        chk(rv, 32'd50);
        ewid(`PSG_OFS_PER_HI, 32'd40, 8);
        chk(rv, 32'd500);
        wr(`PSG_OFS_PER_HI, 32'd0);
        ewid(`PSG_OFS_PER_LO, 32'd10, 8);
        ewid(`PSG_OFS_WID_LO, 32'd99, 8);
        chk(rv, 32'd39);
        ewid(`PSG_OFS_PER_LO, 32'd100, 8);
        ewid(`PSG_OFS_DUTY, 32'd50, 60);
        chk(rv, 32'd50);
        ewid(`PSG_OFS_DUTY, 32'd0, 60);
        chk(rv, 32'd10);
        wr(`PSG_OFS_EDGE, 32'hc8);
        ewid(`PSG_OFS_PER_LO, 32'd50, 8);
        chk({rv, edge_o}, {32'd10, 8'h06});
        ewid(`PSG_OFS_PER_LO, 32'd100, 8);
        chk({rv, edge_o}, {32'd40, 8'h19});
        ewid(`PSG_OFS_DUTY, 32'd200, 60);
        chk({rv, edge_o}, {32'd60, 8'h19});
        wr(`PSG_OFS_EDGE, 32'h2);
        cyc(8);
        chk(edge_o, 8'h05);
        $display("pulse timing test done");
    endtask
    task automatic t_modes;
        lvl(0, 1'b0);
        lvl(2, 1'b1);
        wr(`PSG_OFS_CTRL, 32'h022);
        cyc(4);
        chk(sync_o, 1'b1);
        wr(`PSG_OFS_CTRL, 32'h062);
        cyc(4);
        chk(sync_o, 1'b0);
        lvl(2, 1'b0);
        wr(`PSG_OFS_CTRL, 32'h082);
        for (int i = 0; i < 5; i++)
        begin
            if (i == 2)
                wr(`PSG_OFS_CTRL, 32'h180);
            lvl(i == 4 ? 5 : 3 + i % 2, 1'b1);
            lvl(i == 4 ? 5 : 3 + i % 2, 1'b0);
            cyc(3);
            chk(sync_o, i == 0 || i == 2 || i == 3);
        end
        $display("modulation and sweep test done");
    endtask
    task automatic t_burst;
        wr(`PSG_OFS_CTRL, 32'h202);
        lvl(6, 1'b1);
        lvl(6, 1'b0);
        cyc(3);
        chk(sync_o, 1'b1);
        lvl(7, 1'b1);
        lvl(7, 1'b0);
        cyc(3);
        chk(sync_o, 1'b0);
        wr(`PSG_OFS_CTRL, 32'ha02);
        lvl(0, 1'b1);
        cyc(4);
        chk(sync_o, 1'b1);
        lvl(0, 1'b0);
        wr(`PSG_OFS_CTRL, 32'h602);
        gate_i <= 1'b1;
        cyc(6);
        chk(sync_o, 1'b1);
        gate_i <= 1'b0;
        cyc(6);
        chk(sync_o, 1'b1);
        lvl(8, 1'b1);
        lvl(8, 1'b0);
        cyc(3);
        chk(sync_o, 1'b0);
        $display("burst test done");
    endtask
    // ********************************************************************
    // Verdict, sequence and watchdog
    // ********************************************************************
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset;
        t_polarity;
        t_funcs;
        t_pulse;
        t_modes;
        t_burst;
        give_verdict;
    end
    initial
    begin
        #160000;
        mismatches++;
        give_verdict;
    end
endmodule
`default_nettype wire

// ===== test/psg_rx.sv
// Receiving equipment model: measures high time and period of one line
`default_nettype none
module psg_rx (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic line_i,
    output logic [15:0] hi_len_o,
    output logic [15:0] per_len_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] hi_r;
    logic [15:0] per_r;
    logic prev_r;
    // Count cycles, latch at each edge of the line
    always @(posedge clk_sys_i)
    begin
        prev_r <= line_i;
        hi_r <= hi_r + 16'h1;
        per_r <= per_r + 16'h1;
        if (rst_i)
        begin
            hi_len_o <= 16'h0;
            per_len_o <= 16'h0;
        end
        else if (line_i && !prev_r)
        begin
            per_len_o <= per_r;
            per_r <= 16'h1;
            hi_r <= 16'h1;
        end
        else if (!line_i && prev_r)
            hi_len_o <= hi_r;
    end
endmodule
`default_nettype wire
